//--- hdl/usb_role_power_map.vh
/*
  register offsets, field positions, reset values and state codes of the
  usb role and power control block.
  assumes a 32-bit avalon-mm slave port, one aligned word per register.
*/
`ifndef USB_ROLE_POWER_MAP_VH
`define USB_ROLE_POWER_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_GEN_CTRL 8'h00
`define OFF_GEN_STAT 8'h04
`define OFF_GEN_INT 8'h08
`define OFF_GEN_IEN 8'h0c
`define OFF_DP_PTR 8'h10
`define OFF_DP_DATA 8'h14
`define OFF_SIDE_INT 8'h18
`define OFF_SIDE_IEN 8'h1c

// ----------------------------------------------------------------------
// general_control_reg fields
// ----------------------------------------------------------------------
`define CTL_ENABLE 0
`define CTL_FREEZE 1
`define CTL_HOSTSEL 2
`define CTL_DPRAM_DIRECT_ACCESS_ENABLE 3
`define CTL_SPD_LO 4
`define CTL_SPD_HI 5
`define CTL_FREEZE_RST 1'b1

// ----------------------------------------------------------------------
// general_status_reg fields
// ----------------------------------------------------------------------
`define STA_ROLE 0
`define STA_SUPPLY 1
`define STA_ST_LO 2
`define STA_ST_HI 3
`define STA_DEV_EN 4
`define STA_HOST_EN 5

// ----------------------------------------------------------------------
// general_int_reg flag positions
// ----------------------------------------------------------------------
`define GI_ROLE_PIN 0
`define GI_SUPPLY 1
`define GI_SESSION 2
`define GI_SWAP 3
`define GI_DROP 4
`define GI_BCONN 5
`define GI_NEGO 6
`define GI_STO 7
`define GI_W 8

// ----------------------------------------------------------------------
// controller states and global sources
// ----------------------------------------------------------------------
`define ST_RESET 2'h0
`define ST_DEVICE 2'h1
`define ST_HOST 2'h2
`define SRC_GEN 0
`define SRC_DEV 1
`define SRC_EP 2
`define SRC_HOST 3
`define SRC_PIPE 4
`define SRC_W 5

`endif

//--- hdl/sticky_flags.v
/*
  bank of latched interrupt flags with write-one acknowledge and an
  enable mask, one registered request output.
  assumes set, acknowledge and clear inputs are synchronous one-cycle terms.
*/
module sticky_flags #(
  parameter W = 8
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire clr_all_i,
  input wire [W-1:0] set_i,
  input wire [W-1:0] ack_i,
  input wire [W-1:0] en_i,
  output reg [W-1:0] flags_o,
  output reg irq_o
);
  // ----------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------
  wire [W-1:0] flags_nxt;

  // set wins over acknowledge and over clear
  assign flags_nxt = clr_all_i ? set_i : ((flags_o & ~ack_i) | set_i);

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      flags_o <= {W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      flags_o <= flags_nxt;
      irq_o <= |(flags_nxt & en_i);
    end
  end
endmodule

//--- hdl/dpram_store.v
/*
  byte-wide endpoint and pipe memory with combinational read.
  assumes one write per cycle; contents are never cleared by reset.
*/
module dpram_store #(
  parameter DEPTH = 2368,
  parameter AW = 11
) (
  input wire ref_clk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg [7:0] mem [0:DEPTH-1];

  // out-of-range pointers read zero and drop writes
  assign rdata_o = (addr_i < DEPTH) ? mem[addr_i] : 8'h00;

  always @(posedge ref_clk_i) begin
    if (we_i && (addr_i < DEPTH)) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

//--- hdl/usb_role_power_control.v
/*
  top-level control of a dual-role usb controller: enable and reset
  state, role selection from the role pin, shared host/device interrupt
  registers, global interrupt sources, clock freeze and wake requests.
  assumes all inputs synchronous to ref_clk_i and an avalon-mm master
  that holds each request until waitrequest is sampled low.

  // Summary of operation
  // - controller stays disabled after hardware reset
  // - pin high: role flag set, device selected
  // - pin low: flag cleared, host replaces device
  // - host-select bit alone picks register set
  // - reset state: disabled, frozen, pad suspended
  // - dpram access and speed bits writable in reset
  // - enable enters role state, controller idle
  // - clearing enable acts as hardware reset
  // - five global interrupt sources toward cpu
  // - processing flags: role, supply, session, swap
  // - exception flags: drop, bconnect, negotiation, timeout
  // - any usb interrupt wakes idle cpu
  // - power-down wake on role-specific and pin events
  // - freeze stops core clock, registers stay reachable
  // - while frozen only wake, role, supply raise
  // - clearing enable zeroes speed configuration
*/
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`include "usb_role_power_map.vh"

module usb_role_power_control #(
  parameter DP_DEPTH = 2368,
  parameter DP_AW = 11
) (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire role_pin_i,
  input wire supply_valid_i,
  input wire session_request_evt_i,
  input wire role_swap_evt_i,
  input wire supply_drop_evt_i,
  input wire b_connect_err_evt_i,
  input wire role_negotiation_err_evt_i,
  input wire suspend_timeout_evt_i,
  input wire bus_activity_evt_i,
  input wire remote_resume_evt_i,
  input wire endpoint_irq_i,
  input wire pipe_irq_i,
  output reg [4:0] irq_src_o,
  output reg usb_irq_o,
  output reg idle_wake_o,
  output reg powerdown_wake_o,
  output reg device_ctrl_en_o,
  output reg host_ctrl_en_o,
  output reg core_clk_en_o,
  output reg pad_suspend_o,
  output reg ctrl_reset_o,
  output reg [1:0] speed_config_o,
  output reg role_detect_flag_o
);
  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer k;
    begin
      be_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[8*k +: 8] = new_v[8*k +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg ctrl_enable_r;
  reg clock_freeze_r;
  reg host_select_r;
  reg dpram_direct_access_enable_r;
  reg [1:0] speed_config_r;
  reg [DP_AW-1:0] dpram_pointer_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg role_detect_flag_r;
  reg supply_r;
  reg [31:0] rd_mux;
  wire req;
  wire cap;
  wire done;
  wire wr_done;
  wire rd_done;
  wire [31:0] ctl_word;
  wire [31:0] ctl_new;
  wire [31:0] ptr_new;
  wire enable_fall;
  wire events_open;
  wire [`GI_W-1:0] gen_set;
  wire [`GI_W-1:0] gen_ack;
  wire [`GI_W-1:0] gen_ien;
  wire [`GI_W-1:0] gen_flags;
  wire gen_irq;
  wire dev_flag;
  wire dev_irq;
  wire host_flag;
  wire host_irq;
  wire dev_set;
  wire host_set;
  wire dev_ack;
  wire host_ack;
  wire [7:0] dp_rdata;
  wire dp_we;
  reg [`GI_W-1:0] gen_ien_r;
  reg dev_ien_r;
  reg host_ien_r;
  reg [4:0] src_nxt;
  wire pd_nxt;

  // ----------------------------------------------------------------------
  // avalon handshake
  // ----------------------------------------------------------------------
  // two-edge access: first edge captures read data, second completes
  assign req = avs_read_i | avs_write_i;
  assign cap = req & avs_waitrequest_o;
  assign done = req & ~avs_waitrequest_o;
  assign wr_done = done & avs_write_i;
  assign rd_done = done & avs_read_i;

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~cap;
      if (cap && avs_read_i) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0;
    if (avs_address_i == `OFF_GEN_CTRL) begin
      rd_mux = ctl_word;
    end else if (avs_address_i == `OFF_GEN_STAT) begin
      rd_mux[`STA_ROLE] = role_detect_flag_r;
      rd_mux[`STA_SUPPLY] = supply_r;
      rd_mux[`STA_ST_HI:`STA_ST_LO] = state_r;
      rd_mux[`STA_DEV_EN] = (state_r == `ST_DEVICE);
      rd_mux[`STA_HOST_EN] = (state_r == `ST_HOST);
    end else if (avs_address_i == `OFF_GEN_INT) begin
      rd_mux[`GI_W-1:0] = gen_flags;
    end else if (avs_address_i == `OFF_GEN_IEN) begin
      rd_mux[`GI_W-1:0] = gen_ien_r;
    end else if (avs_address_i == `OFF_DP_PTR) begin
      rd_mux[DP_AW-1:0] = dpram_pointer_r;
    end else if (avs_address_i == `OFF_DP_DATA) begin
      rd_mux[7:0] = dpram_direct_access_enable_r ? dp_rdata : 8'h00;
    end else if (avs_address_i == `OFF_SIDE_INT) begin
      rd_mux[0] = host_select_r ? host_flag : dev_flag;
    end else if (avs_address_i == `OFF_SIDE_IEN) begin
      rd_mux[0] = host_select_r ? host_ien_r : dev_ien_r;
    end
  end

  // ----------------------------------------------------------------------
  // general control register
  // ----------------------------------------------------------------------
  assign ctl_word = {26'h0, speed_config_r, dpram_direct_access_enable_r,
                     host_select_r, clock_freeze_r, ctrl_enable_r};
  assign ctl_new = be_merge(ctl_word, avs_writedata_i, avs_byteenable_i);
  assign enable_fall = wr_done & (avs_address_i == `OFF_GEN_CTRL) &
                       ctrl_enable_r & ~ctl_new[`CTL_ENABLE];

  // writes are taken in any state, frozen or not
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl_enable_r <= 1'b0;
      clock_freeze_r <= `CTL_FREEZE_RST;
      host_select_r <= 1'b0;
      dpram_direct_access_enable_r <= 1'b0;
      speed_config_r <= 2'h0;
    end else if (wr_done && (avs_address_i == `OFF_GEN_CTRL)) begin
      ctrl_enable_r <= ctl_new[`CTL_ENABLE];
      host_select_r <= ctl_new[`CTL_HOSTSEL];
      dpram_direct_access_enable_r <= ctl_new[`CTL_DPRAM_DIRECT_ACCESS_ENABLE];
      if (enable_fall) begin
        clock_freeze_r <= `CTL_FREEZE_RST;
        speed_config_r <= 2'h0;
      end else begin
        clock_freeze_r <= ctl_new[`CTL_FREEZE];
        speed_config_r <= ctl_new[`CTL_SPD_HI:`CTL_SPD_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // dpram direct access
  // ----------------------------------------------------------------------
  assign ptr_new = be_merge({{(32-DP_AW){1'b0}}, dpram_pointer_r},
                            avs_writedata_i, avs_byteenable_i);
  assign dp_we = wr_done & (avs_address_i == `OFF_DP_DATA) &
                 dpram_direct_access_enable_r & avs_byteenable_i[0];

  // pointer advances after each data port access when direct access is enabled; usable while disabled
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      dpram_pointer_r <= {DP_AW{1'b0}};
    end else if (wr_done && (avs_address_i == `OFF_DP_PTR)) begin
      dpram_pointer_r <= ptr_new[DP_AW-1:0];
    end else if (done && (avs_address_i == `OFF_DP_DATA) &&
                 dpram_direct_access_enable_r) begin
      dpram_pointer_r <= dpram_pointer_r + {{(DP_AW-1){1'b0}}, 1'b1};
    end
  end

  // contents survive both resets
  dpram_store #(
    .DEPTH(DP_DEPTH),
    .AW(DP_AW)
  ) u_dpram (
    .ref_clk_i(ref_clk_i),
    .we_i(dp_we),
    .addr_i(dpram_pointer_r),
    .wdata_i(avs_writedata_i[7:0]),
    .rdata_o(dp_rdata)
  );

  // ----------------------------------------------------------------------
  // role detection and controller state
  // ----------------------------------------------------------------------
  // an open pin reads high through the pad pull-up
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_RESET: begin
        if (ctrl_enable_r) begin
          state_nxt = role_pin_i ? `ST_DEVICE : `ST_HOST;
        end
      end
      `ST_DEVICE: begin
        if (!role_pin_i) begin
          state_nxt = `ST_HOST;
        end
      end
      `ST_HOST: begin
        if (role_pin_i) begin
          state_nxt = `ST_DEVICE;
        end
      end
      default: begin
        state_nxt = `ST_RESET;
      end
    endcase
    if (!ctrl_enable_r) begin
      state_nxt = `ST_RESET;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= `ST_RESET;
      role_detect_flag_r <= 1'b1;
      supply_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      role_detect_flag_r <= role_pin_i;
      supply_r <= supply_valid_i;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------------
  // frozen or stopped core raises only wake, role and supply events
  assign events_open = ~clock_freeze_r & (state_r != `ST_RESET);

  assign gen_set[`GI_ROLE_PIN] = role_pin_i ^ role_detect_flag_r;
  assign gen_set[`GI_SUPPLY] = supply_valid_i ^ supply_r;
  assign gen_set[`GI_SESSION] = session_request_evt_i & events_open;
  assign gen_set[`GI_SWAP] = role_swap_evt_i & events_open;
  assign gen_set[`GI_DROP] = supply_drop_evt_i & events_open;
  assign gen_set[`GI_BCONN] = b_connect_err_evt_i & events_open;
  assign gen_set[`GI_NEGO] = role_negotiation_err_evt_i & events_open;
  assign gen_set[`GI_STO] = suspend_timeout_evt_i & events_open;
  assign gen_ack = (wr_done && (avs_address_i == `OFF_GEN_INT)) ?
                   avs_writedata_i[`GI_W-1:0] : {`GI_W{1'b0}};
  assign gen_ien = gen_ien_r;

  assign dev_set = bus_activity_evt_i;
  assign host_set = remote_resume_evt_i & events_open;
  assign dev_ack = wr_done & (avs_address_i == `OFF_SIDE_INT) &
                   ~host_select_r & avs_writedata_i[0];
  assign host_ack = wr_done & (avs_address_i == `OFF_SIDE_INT) &
                    host_select_r & avs_writedata_i[0];

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      gen_ien_r <= {`GI_W{1'b0}};
      dev_ien_r <= 1'b0;
      host_ien_r <= 1'b0;
    end else if (wr_done && (avs_address_i == `OFF_GEN_IEN)) begin
      gen_ien_r <= avs_writedata_i[`GI_W-1:0];
    end else if (wr_done && (avs_address_i == `OFF_SIDE_IEN)) begin
      if (host_select_r) begin
        host_ien_r <= avs_writedata_i[0];
      end else begin
        dev_ien_r <= avs_writedata_i[0];
      end
    end
  end

  sticky_flags #(
    .W(`GI_W)
  ) u_gen_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_all_i(enable_fall),
    .set_i(gen_set),
    .ack_i(gen_ack),
    .en_i(gen_ien),
    .flags_o(gen_flags),
    .irq_o(gen_irq)
  );

  sticky_flags #(
    .W(1)
  ) u_dev_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_all_i(enable_fall),
    .set_i(dev_set),
    .ack_i(dev_ack),
    .en_i(dev_ien_r),
    .flags_o(dev_flag),
    .irq_o(dev_irq)
  );

  sticky_flags #(
    .W(1)
  ) u_host_flags (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clr_all_i(enable_fall),
    .set_i(host_set),
    .ack_i(host_ack),
    .en_i(host_ien_r),
    .flags_o(host_flag),
    .irq_o(host_irq)
  );

  // ----------------------------------------------------------------------
  // global sources and wake requests
  // ----------------------------------------------------------------------
  // engine requests are level inputs, gated by role and freeze
  always @* begin
    src_nxt = 5'h00;
    src_nxt[`SRC_GEN] = gen_irq;
    src_nxt[`SRC_DEV] = dev_irq;
    src_nxt[`SRC_EP] = endpoint_irq_i & events_open &
                       (state_r == `ST_DEVICE);
    src_nxt[`SRC_HOST] = host_irq;
    src_nxt[`SRC_PIPE] = pipe_irq_i & events_open &
                         (state_r == `ST_HOST);
  end

  // power-down wake looks at raw flags: enables may be off while asleep
  assign pd_nxt = (dev_flag & ~host_select_r) |
                  ((host_flag | gen_flags[`GI_SESSION]) & host_select_r) |
                  gen_flags[`GI_ROLE_PIN] | gen_flags[`GI_SUPPLY];

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_src_o <= 5'h00;
      usb_irq_o <= 1'b0;
      idle_wake_o <= 1'b0;
      powerdown_wake_o <= 1'b0;
    end else begin
      irq_src_o <= src_nxt;
      usb_irq_o <= |src_nxt;
      idle_wake_o <= |src_nxt;
      powerdown_wake_o <= pd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // core controls
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      device_ctrl_en_o <= 1'b0;
      host_ctrl_en_o <= 1'b0;
      core_clk_en_o <= 1'b0;
      pad_suspend_o <= 1'b1;
      ctrl_reset_o <= 1'b1;
      speed_config_o <= 2'h0;
      role_detect_flag_o <= 1'b1;
    end else begin
      device_ctrl_en_o <= (state_nxt == `ST_DEVICE);
      host_ctrl_en_o <= (state_nxt == `ST_HOST);
      core_clk_en_o <= (state_nxt != `ST_RESET) & ~clock_freeze_r;
      pad_suspend_o <= (state_nxt == `ST_RESET);
      ctrl_reset_o <= (state_nxt == `ST_RESET);
      speed_config_o <= speed_config_r;
      role_detect_flag_o <= role_pin_i;
    end
  end
endmodule

//--- test/usb_role_power_control_assertions.sv
/*
  checker of the usb role and power control block, bound to its top.
  assumes the top's ports only and a master holding requests until answered.
*/
`include "usb_role_power_map.vh"
module usb_role_power_checker (
  input wire ref_clk_i,
  input wire nrst_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_waitrequest_o,
  input wire role_pin_i,
  input wire [4:0] irq_src_o,
  input wire usb_irq_o,
  input wire idle_wake_o,
  input wire device_ctrl_en_o,
  input wire host_ctrl_en_o,
  input wire core_clk_en_o,
  input wire pad_suspend_o,
  input wire ctrl_reset_o,
  input wire [1:0] speed_config_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  wire ctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == `OFF_GEN_CTRL
    && avs_byteenable_i[0];
  AST_RESET_STATE: assert property (ctrl_reset_o |-> !core_clk_en_o &&
    !device_ctrl_en_o && !host_ctrl_en_o) else $error("reset state not quiet");
  AST_PAD_SUSPEND: assert property (pad_suspend_o == ctrl_reset_o)
    else $error("pad suspend wrong");
  AST_ONE_CTRL: assert property (!(device_ctrl_en_o && host_ctrl_en_o))
    else $error("both controllers on");
  AST_DEV_ROLE: assert property (!ctrl_reset_o && role_pin_i && $past(role_pin_i) &&
    $past(role_pin_i, 2) && $past(role_pin_i, 3) |-> device_ctrl_en_o)
    else $error("device not selected");
  AST_HOST_ROLE: assert property (!ctrl_reset_o && !role_pin_i && !$past(role_pin_i) &&
    !$past(role_pin_i, 2) && !$past(role_pin_i, 3) |-> host_ctrl_en_o)
    else $error("host not selected");
  AST_ENTER_DEV: assert property (ctl_wr && avs_writedata_i[0] && ctrl_reset_o &&
    role_pin_i && $past(role_pin_i) |=> ##[0:2] device_ctrl_en_o)
    else $error("enable did not start device");
  AST_ENABLE_OFF: assert property (ctl_wr && !avs_writedata_i[0] && !ctrl_reset_o
    |=> ##1 speed_config_o == 2'h0 ##[0:1] ctrl_reset_o) else $error("disable not a reset");
  AST_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer late");
  AST_CORE_CLK: assert property (core_clk_en_o |-> !ctrl_reset_o)
    else $error("core clock in reset");
  AST_GLOBAL_OR: assert property (usb_irq_o == (|irq_src_o))
    else $error("global request mismatch");
  AST_IDLE_WAKE: assert property (idle_wake_o == usb_irq_o)
    else $error("idle wake mismatch");
  AST_LATCHED: assert property (irq_src_o[0] && !avs_write_i && !$past(avs_write_i)
    && !$past(avs_write_i, 2) |=> irq_src_o[0]) else $error("flag lost without ack");
  cover property (ctl_wr && !avs_writedata_i[0] && !ctrl_reset_o);
  cover property (host_ctrl_en_o && usb_irq_o);
  cover property (!core_clk_en_o && !ctrl_reset_o);
endmodule
bind usb_role_power_control usb_role_power_checker chk (.ref_clk_i, .nrst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
  .role_pin_i, .irq_src_o, .usb_irq_o, .idle_wake_o, .device_ctrl_en_o, .host_ctrl_en_o,
  .core_clk_en_o, .pad_suspend_o, .ctrl_reset_o, .speed_config_o);

//--- test/usb_far_end.sv
/*
  far side of the cable: role pin, supply level and one-cycle event pulses.
  assumes the bench calls its tasks; all changes land just after a rising edge.
*/
module usb_far_end (
  input wire ref_clk_i,
  output logic role_pin_o,
  output logic supply_valid_o,
  output logic [7:0] evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // unconnected pin reads high through the pull-up
  initial begin
    role_pin_o = 1'b1;
    supply_valid_o = 1'b0;
    evt_o = 8'h00;
  end
  // 0 session, 1 swap, 2 drop, 3 bconn, 4 nego, 5 timeout, 6 wake, 7 resume
  task automatic pulse(input int i);
    @(posedge ref_clk_i);
    evt_o[i] <= 1'b1;
    @(posedge ref_clk_i);
    evt_o[i] <= 1'b0;
  endtask
  task automatic set_role(input logic v);
    @(posedge ref_clk_i);
    role_pin_o <= v;
  endtask
  // plug or unplug, seen as a supply change
  task automatic toggle_supply();
    @(posedge ref_clk_i);
    supply_valid_o <= !supply_valid_o;
  endtask
endmodule

//--- test/usb_role_power_control_test.sv
/*
  self-checking bench: register tasks over avalon-mm and port checks.
  assumes the far end model and one 25 mhz clock with synchronous reset.
*/
`include "usb_role_power_map.vh"
module usb_role_power_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, rd = 0, wr = 0, pipe = 0, ep = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] wd = 32'h0;
  wire [31:0] rdata;
  wire wreq, rp, sv, uirq, iwake, pwake, den, hen, cen, pads, crst, rflag;
  wire [7:0] ev;
  wire [4:0] src;
  wire [1:0] spd;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  usb_far_end far (.ref_clk_i(clk), .role_pin_o(rp), .supply_valid_o(sv), .evt_o(ev));
  usb_role_power_control dut (.ref_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .role_pin_i(rp), .supply_valid_i(sv),
    .session_request_evt_i(ev[0]), .role_swap_evt_i(ev[1]), .supply_drop_evt_i(ev[2]),
    .b_connect_err_evt_i(ev[3]), .role_negotiation_err_evt_i(ev[4]),
    .suspend_timeout_evt_i(ev[5]), .bus_activity_evt_i(ev[6]), .remote_resume_evt_i(ev[7]),
    .endpoint_irq_i(ep), .pipe_irq_i(pipe), .irq_src_o(src), .usb_irq_o(uirq),
    .idle_wake_o(iwake), .powerdown_wake_o(pwake), .device_ctrl_en_o(den),
    .host_ctrl_en_o(hen), .core_clk_en_o(cen), .pad_suspend_o(pads), .ctrl_reset_o(crst),
    .speed_config_o(spd), .role_detect_flag_o(rflag));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low, data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n == 50) n_mismatch++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic set_eng(input logic e, input logic p);
    @(posedge clk);
    ep <= e;
    pipe <= p;
  endtask
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    settle();
    check({crst, pads, cen, den, hen}, 5'b11000);
    rdc(`OFF_GEN_CTRL, 32'h02);
    // no byte lanes: write answered but ignored
    be <= 4'h0;
    wrt(`OFF_GEN_CTRL, 32'h01);
    be <= 4'hf;
    rdc(`OFF_GEN_CTRL, 32'h02);
    // pointer wraps at 11 bits; memory reachable while disabled
    wrt(`OFF_GEN_CTRL, 32'h3a);
    wrt(`OFF_DP_PTR, 32'h7fe);
    wrt(`OFF_DP_DATA, 32'ha5);
    wrt(`OFF_DP_DATA, 32'h5a);
    rdc(`OFF_DP_PTR, 32'h000);
    wrt(`OFF_DP_PTR, 32'h7fe);
    rdc(`OFF_DP_DATA, 32'ha5);
    rdc(`OFF_DP_DATA, 32'h5a);
    settle();
    check({crst, spd}, 3'b111);
    rdc(8'h40, 32'h0);
    wrt(`OFF_GEN_CTRL, 32'h01);
    settle();
    check({crst, den, hen, cen, pads}, 5'b01010);
    rdc(`OFF_GEN_STAT, 32'h15);
    rdc(`OFF_GEN_INT, 32'h0);
    // device role forwards endpoint requests only
    set_eng(1'b1, 1'b1);
    settle();
    check(src, 5'h04);
    set_eng(1'b0, 1'b0);
    wrt(`OFF_GEN_IEN, 32'hff);
    far.set_role(1'b0);
    settle();
    check({den, hen, rflag}, 3'b010);
    rdc(`OFF_GEN_STAT, 32'h28);
    rdc(`OFF_GEN_INT, 32'h01);
    check({src, uirq, iwake, pwake}, 8'h0f);
    wrt(`OFF_GEN_INT, 32'h01);
    settle();
    rdc(`OFF_GEN_INT, 32'h0);
    check({uirq, pwake}, 2'b00);
    wrt(`OFF_GEN_IEN, 32'h0);
    far.pulse(0);
    settle();
    check(uirq, 1'b0);
    wrt(`OFF_GEN_IEN, 32'hff);
    settle();
    check(uirq, 1'b1);
    wrt(`OFF_GEN_INT, 32'hff);
    for (int i = 0; i < 6; i++) begin
      far.pulse(i);
      rdc(`OFF_GEN_INT, 32'h1 << (`GI_SESSION + i));
      wrt(`OFF_GEN_INT, 32'hff);
    end
    far.toggle_supply();
    settle();
    rdc(`OFF_GEN_INT, 32'h02);
    rdc(`OFF_GEN_STAT, 32'h2a);
    wrt(`OFF_GEN_INT, 32'hff);
    // shared offsets: host_select alone picks the bank
    wrt(`OFF_GEN_CTRL, 32'h05);
    wrt(`OFF_SIDE_IEN, 32'h1);
    far.pulse(7);
    settle();
    rdc(`OFF_SIDE_INT, 32'h1);
    check({src, pwake}, 6'b010001);
    wrt(`OFF_GEN_CTRL, 32'h01);
    rdc(`OFF_SIDE_INT, 32'h0);
    wrt(`OFF_GEN_CTRL, 32'h05);
    wrt(`OFF_SIDE_INT, 32'h1);
    rdc(`OFF_SIDE_INT, 32'h0);
    set_eng(1'b1, 1'b1);
    settle();
    check(src, 5'h10);
    set_eng(1'b0, 1'b0);
    wrt(`OFF_GEN_CTRL, 32'h07);
    settle();
    check(cen, 1'b0);
    far.pulse(0);
    far.pulse(7);
    settle();
    rdc(`OFF_GEN_INT, 32'h0);
    rdc(`OFF_SIDE_INT, 32'h0);
    far.toggle_supply();
    settle();
    rdc(`OFF_GEN_INT, 32'h02);
    // bus-activity wake still raises while frozen
    far.pulse(6);
    wrt(`OFF_GEN_CTRL, 32'h03);
    rdc(`OFF_SIDE_INT, 32'h1);
    wrt(`OFF_GEN_CTRL, 32'h37);
    settle();
    check(spd, 2'h3);
    wrt(`OFF_GEN_CTRL, 32'h30);
    settle();
    check({crst, spd, hen, pads}, 5'b10001);
    rdc(`OFF_GEN_CTRL, 32'h02);
    rdc(`OFF_GEN_INT, 32'h0);
    close_out();
  end
endmodule
